// file: rtl/uart_mcls_pkg.sv
// package for the uart modem-control and line-status block
// assumes an apb slave with 32-bit data and byte addresses
package uart_mcls_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_RX_HOLDING = 8'h00;
  localparam logic [7:0] OFS_ENH_FEATURE = 8'h04;
  localparam logic [7:0] OFS_MODEM_CONTROL = 8'h08;
  localparam logic [7:0] OFS_LINE_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MODEM_STATUS = 8'h10;
  localparam logic [7:0] OFS_FLOW_THRESHOLD = 8'h14;
  localparam logic [7:0] OFS_TRIGGER_LEVEL = 8'h18;
  localparam logic [7:0] OFS_PIN_FUNCTION = 8'h1C;
  localparam logic [7:0] OFS_PORT_PIN_STATE = 8'h20;

  // modem control fields
  localparam int MC_PRESCALE = 7;
  localparam int MC_IRDA = 6;
  localparam int MC_XON_ANY = 5;
  localparam int MC_LOOPBACK = 4;
  localparam int MC_THRESH_EN = 2;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  // bits that need the enhanced write enable
  localparam logic [7:0] MC_LOCKED_MASK = 8'hE4;

  // enhanced feature fields
  localparam int EF_WRITE_EN = 4;
  localparam int EF_AUTO_RTS = 6;

  // pin function select and port pin state fields
  localparam int PFS_DTR_SEL = 1;
  localparam int PPS_SHARED_PIN = 5;

  // line status fields
  localparam int LS_FIFO_ERR = 7;
  localparam int LS_TX_ALL_EMPTY = 6;
  localparam int LS_HOLD_EMPTY = 5;
  localparam int LS_BREAK = 4;
  localparam int LS_FRAMING = 3;
  localparam int LS_PARITY = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_DATA_READY = 0;

  // modem status fields
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;

  // receive fifo entry layout: {break, framing, parity, data}
  localparam int ENT_BREAK = 10;
  localparam int ENT_FRAMING = 9;
  localparam int ENT_PARITY = 8;
  localparam int RX_DEPTH = 64;
  localparam logic [7:0] BREAK_CHAR = 8'h00;

  // reset values
  localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] RST_ENH_FEATURE = 8'h00;
  localparam logic [7:0] RST_FLOW_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_TRIGGER_LEVEL = 8'h00;
  localparam logic [7:0] RST_PIN_FUNCTION = 8'h00;
  localparam logic [7:0] RST_PORT_PIN_STATE = 8'h00;

  // prescaler last count in divide-by-4 mode
  localparam logic [1:0] DIV4_LAST = 2'h3;

endpackage

// file: rtl/uart_mcls.sv
// uart modem-control and line-status logic for one channel, apb register slave
// assumes receiver and transmitter cores on pclk; modem pins are asynchronous
//
// Function
// R1 - control bit 7 selects prescale by four
// R2 - control bit 6 selects irda line mode
// R3 - control bit 5 enables xon-any
// R4 - loopback routes tx to rx, controls to status
// R5 - control bit 2 gates threshold/trigger registers
// R6 - control bit 1 drives active-low rts
// R7 - auto rts lets flow logic drive rts
// R8 - control bit 0 drives dtr shared pin
// R9 - locked control bits need enhanced write enable
// R10 - status bit 7: error anywhere in fifo
// R11 - status bit 6: holding and shift empty
// R12 - status bit 5: holding register empty
// R13 - status bit 4: break, stored char zero
// R14 - status bit 3: framing error of head
// R15 - status bit 2: parity error of head
// R16 - status bit 1: receive overrun occurred
// R17 - status bit 0: receive fifo not empty
// R18 - error bits follow head fifo character
// R19 - host reads status before holding register
// R20 - modem status cts bit, looped in loopback
// R21 - overrun stays until status read clears
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module uart_mcls
  import uart_mcls_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receiver core
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_break,
  input wire logic rx_char_framing,
  input wire logic rx_char_parity,
  output logic rx_serial_to_core,
  // transmitter core
  input wire logic tx_serial_from_core,
  input wire logic tx_hold_empty,
  input wire logic tx_shift_empty,
  // flow control core
  input wire logic auto_rts_level_n,
  // mode outputs
  output logic baud_clk_en,
  output logic irda_mode,
  output logic xon_any_en,
  output logic [7:0] flow_threshold,
  output logic [7:0] fifo_trigger_level,
  // serial and modem pins
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic cts_pin_n,
  input wire logic dsr_pin_n,
  output logic rts_pin_n,
  output logic shared_pin_b_five
);

  typedef struct packed {
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] flow_threshold_reg;
    logic [7:0] fifo_trigger_level_reg;
    logic [7:0] pin_function_select;
    logic [7:0] port_pin_state;
    logic [RX_DEPTH-1:0][10:0] rx_mem;
    logic [5:0] wr_ptr;
    logic [5:0] rd_ptr;
    logic [6:0] rx_count;
    logic [6:0] err_count;
    logic overrun;
    logic [1:0] prescale_cnt;
    logic [31:0] rdata;
    logic slverr;
    logic [1:0] rx_sync;
    logic [1:0] cts_sync;
    logic [1:0] dsr_sync;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic setup_ph;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic loopback;
  logic div4;
  logic [10:0] head;
  logic head_valid;
  logic rx_full;
  logic push;
  logic pop;
  logic push_err;
  logic pop_err;
  logic overrun_evt;
  logic [7:0] line_status_val;
  logic [7:0] modem_status_val;
  logic thresh_open;
  logic [7:0] ctrl_wval;

  assign setup_ph = psel && !penable;
  assign access_done = psel && penable;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;
  assign loopback = st_r.modem_control_reg[MC_LOOPBACK];
  assign div4 = st_r.modem_control_reg[MC_PRESCALE];
  assign head = st_r.rx_mem[st_r.rd_ptr];
  assign head_valid = (st_r.rx_count != 7'h00);
  assign rx_full = (st_r.rx_count == 7'(RX_DEPTH));
  assign thresh_open = st_r.enhanced_feature_reg[EF_WRITE_EN]
                       && st_r.modem_control_reg[MC_THRESH_EN]; // [R5]

  // fifo pointer moves
  assign pop = rd_done && (paddr == OFS_RX_HOLDING) && head_valid;
  assign push = rx_char_valid && (!rx_full || pop);
  assign overrun_evt = rx_char_valid && rx_full && !pop; // [R16]
  assign push_err = push && (rx_char_break || rx_char_framing || rx_char_parity);
  assign pop_err = pop && (head[ENT_BREAK] || head[ENT_FRAMING] || head[ENT_PARITY]);

  // line status view
  always_comb
  begin
    line_status_val = 8'h00;
    line_status_val[LS_FIFO_ERR] = (st_r.err_count != 7'h00); // [R10]
    line_status_val[LS_TX_ALL_EMPTY] = tx_hold_empty && tx_shift_empty; // [R11]
    line_status_val[LS_HOLD_EMPTY] = tx_hold_empty; // [R12]
    line_status_val[LS_BREAK] = head_valid && head[ENT_BREAK]; // [R13] [R18]
    line_status_val[LS_FRAMING] = head_valid && head[ENT_FRAMING]; // [R14] [R18]
    line_status_val[LS_PARITY] = head_valid && head[ENT_PARITY]; // [R15] [R18]
    line_status_val[LS_OVERRUN] = st_r.overrun; // [R16]
    line_status_val[LS_DATA_READY] = head_valid; // [R17]
  end

  // modem status view: cts and dsr only
  always_comb
  begin
    modem_status_val = 8'h00;
    modem_status_val[MS_CTS] = loopback ? st_r.modem_control_reg[MC_RTS]
                                        : !st_r.cts_sync[1]; // [R20] [R4] [R6]
    modem_status_val[MS_DSR] = loopback ? st_r.modem_control_reg[MC_DTR]
                                        : !st_r.dsr_sync[1]; // [R4]
  end

  // locked bits keep their value without the enhanced write enable
  always_comb
  begin
    if (st_r.enhanced_feature_reg[EF_WRITE_EN])
    begin
      ctrl_wval = pwdata[7:0];
    end
    else
    begin
      ctrl_wval = (pwdata[7:0] & ~MC_LOCKED_MASK)
                  | (st_r.modem_control_reg & MC_LOCKED_MASK); // [R9]
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.rx_sync = {st_r.rx_sync[0], rx_pin};
    st_nxt.cts_sync = {st_r.cts_sync[0], cts_pin_n};
    st_nxt.dsr_sync = {st_r.dsr_sync[0], dsr_pin_n};

    // prescaler counts only in divide-by-4 mode
    if (div4)
    begin
      st_nxt.prescale_cnt = st_r.prescale_cnt + 2'h1; // [R1]
    end
    else
    begin
      st_nxt.prescale_cnt = 2'h0;
    end

    // read data and error captured in setup, presented in access
    if (setup_ph)
    begin
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.slverr = 1'b0;
      if (paddr == OFS_RX_HOLDING)
      begin
        st_nxt.rdata[7:0] = head_valid ? head[7:0] : 8'h00;
      end
      else if (paddr == OFS_ENH_FEATURE)
      begin
        st_nxt.rdata[7:0] = st_r.enhanced_feature_reg;
      end
      else if (paddr == OFS_MODEM_CONTROL)
      begin
        st_nxt.rdata[7:0] = st_r.modem_control_reg;
      end
      else if (paddr == OFS_LINE_STATUS)
      begin
        st_nxt.rdata[7:0] = line_status_val;
      end
      else if (paddr == OFS_MODEM_STATUS)
      begin
        st_nxt.rdata[7:0] = modem_status_val;
      end
      else if (paddr == OFS_FLOW_THRESHOLD)
      begin
        st_nxt.rdata[7:0] = thresh_open ? st_r.flow_threshold_reg : 8'h00; // [R5]
      end
      else if (paddr == OFS_TRIGGER_LEVEL)
      begin
        st_nxt.rdata[7:0] = thresh_open ? st_r.fifo_trigger_level_reg : 8'h00; // [R5]
      end
      else if (paddr == OFS_PIN_FUNCTION)
      begin
        st_nxt.rdata[7:0] = st_r.pin_function_select;
      end
      else if (paddr == OFS_PORT_PIN_STATE)
      begin
        st_nxt.rdata[7:0] = st_r.port_pin_state;
      end
      else
      begin
        st_nxt.slverr = 1'b1;
      end
    end

    // register writes at the access edge
    if (wr_done)
    begin
      if (paddr == OFS_ENH_FEATURE)
      begin
        st_nxt.enhanced_feature_reg = pwdata[7:0];
      end
      else if (paddr == OFS_MODEM_CONTROL)
      begin
        st_nxt.modem_control_reg = ctrl_wval; // [R9]
      end
      else if (paddr == OFS_FLOW_THRESHOLD && thresh_open)
      begin
        st_nxt.flow_threshold_reg = pwdata[7:0]; // [R5]
      end
      else if (paddr == OFS_TRIGGER_LEVEL && thresh_open)
      begin
        st_nxt.fifo_trigger_level_reg = pwdata[7:0]; // [R5]
      end
      else if (paddr == OFS_PIN_FUNCTION)
      begin
        st_nxt.pin_function_select = pwdata[7:0];
      end
      else if (paddr == OFS_PORT_PIN_STATE)
      begin
        st_nxt.port_pin_state = pwdata[7:0];
      end
    end

    // receive fifo with per-character error flags
    if (push)
    begin
      st_nxt.rx_mem[st_r.wr_ptr] = {rx_char_break, rx_char_framing, rx_char_parity,
                                    rx_char_break ? BREAK_CHAR : rx_char_data}; // [R13]
      st_nxt.wr_ptr = st_r.wr_ptr + 6'h01;
    end
    if (pop)
    begin
      st_nxt.rd_ptr = st_r.rd_ptr + 6'h01;
    end
    st_nxt.rx_count = st_r.rx_count + {6'h00, push} - {6'h00, pop}; // [R17]
    st_nxt.err_count = st_r.err_count + {6'h00, push_err} - {6'h00, pop_err}; // [R10]

    // overrun: set wins over clear by status read
    if (overrun_evt)
    begin
      st_nxt.overrun = 1'b1; // [R16]
    end
    else if (rd_done && paddr == OFS_LINE_STATUS)
    begin
      st_nxt.overrun = 1'b0; // [R21]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.modem_control_reg <= RST_MODEM_CONTROL;
      st_r.enhanced_feature_reg <= RST_ENH_FEATURE;
      st_r.flow_threshold_reg <= RST_FLOW_THRESHOLD;
      st_r.fifo_trigger_level_reg <= RST_TRIGGER_LEVEL;
      st_r.pin_function_select <= RST_PIN_FUNCTION;
      st_r.port_pin_state <= RST_PORT_PIN_STATE;
      st_r.rx_sync <= 2'h3;
      st_r.cts_sync <= 2'h3;
      st_r.dsr_sync <= 2'h3;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // bus outputs: zero wait state
  assign pready = 1'b1;
  assign prdata = st_r.rdata;
  assign pslverr = access_done && st_r.slverr;

  // mode outputs
  assign baud_clk_en = !div4 || (st_r.prescale_cnt == DIV4_LAST); // [R1]
  assign irda_mode = st_r.modem_control_reg[MC_IRDA]; // [R2]
  assign xon_any_en = st_r.modem_control_reg[MC_XON_ANY]; // [R3]
  assign flow_threshold = st_r.flow_threshold_reg;
  assign fifo_trigger_level = st_r.fifo_trigger_level_reg;

  // serial path: loopback keeps the line idle high
  assign rx_serial_to_core = loopback ? tx_serial_from_core : st_r.rx_sync[1]; // [R4]
  assign tx_pin = loopback ? 1'b1 : tx_serial_from_core; // [R4]

  // modem outputs
  always_comb
  begin
    if (loopback)
    begin
      rts_pin_n = 1'b1; // [R6]
    end
    else if (st_r.enhanced_feature_reg[EF_AUTO_RTS])
    begin
      rts_pin_n = auto_rts_level_n; // [R7]
    end
    else
    begin
      rts_pin_n = !st_r.modem_control_reg[MC_RTS]; // [R6]
    end
  end

  assign shared_pin_b_five = st_r.pin_function_select[PFS_DTR_SEL]
                             ? !st_r.modem_control_reg[MC_DTR] // [R8]
                             : st_r.port_pin_state[PPS_SHARED_PIN];

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PRESCALE_UNDIV: assert property (!div4 |-> baud_clk_en) // [R1]
    else $error("undivided prescale missed a pulse");
  AST_PRESCALE_DIV4: assert property // [R1]
    ((div4 && baud_clk_en) ##1 div4 |-> !baud_clk_en ##1 (!div4 || !baud_clk_en))
    else $error("divide-by-4 pulse too early");
  AST_CTRL_LOCK: assert property // [R9]
    ((wr_done && paddr == OFS_MODEM_CONTROL && !st_r.enhanced_feature_reg[EF_WRITE_EN])
     |=> ((st_r.modem_control_reg & MC_LOCKED_MASK)
          == ($past(st_r.modem_control_reg) & MC_LOCKED_MASK)))
    else $error("locked control bits changed");
  AST_ERR_ANY: assert property (push_err |=> line_status_val[LS_FIFO_ERR]) // [R10]
    else $error("fifo error flag not set");
  AST_TX_EMPTY: assert property // [R11]
    (setup_ph && !pwrite && paddr == OFS_LINE_STATUS
     |=> prdata[LS_TX_ALL_EMPTY] == ($past(tx_hold_empty) && $past(tx_shift_empty)))
    else $error("transmit empty bit wrong");
  AST_BREAK_ZERO: assert property // [R13]
    (setup_ph && !pwrite && paddr == OFS_RX_HOLDING && head_valid && head[ENT_BREAK]
     |=> prdata[7:0] == BREAK_CHAR)
    else $error("break character not zero");
  AST_HEAD_FLAGS: assert property // [R18]
    (setup_ph && !pwrite && paddr == OFS_LINE_STATUS && head_valid
     |=> prdata[4:2] == $past(head[10:8]))
    else $error("status error bits not from head");
  AST_OVR_SET: assert property // [R16]
    (rx_char_valid && rx_full && !pop |=> st_r.overrun && line_status_val[LS_OVERRUN])
    else $error("overrun not flagged");
  AST_OVR_CLEAR: assert property // [R21]
    (rd_done && paddr == OFS_LINE_STATUS && !overrun_evt |=> !st_r.overrun)
    else $error("overrun not cleared by status read");
  AST_DATA_READY: assert property // [R17]
    (push && !head_valid |=> line_status_val[LS_DATA_READY])
    else $error("data ready not set");
  AST_CTS_LOOP: assert property // [R20]
    (loopback |-> modem_status_val[MS_CTS] == st_r.modem_control_reg[MC_RTS])
    else $error("looped cts wrong");
  AST_AUTO_RTS: assert property // [R7]
    (!loopback && st_r.enhanced_feature_reg[EF_AUTO_RTS] |-> rts_pin_n == auto_rts_level_n)
    else $error("auto rts not followed");

  COV_OVERRUN: cover property (overrun_evt ##[1:20] (rd_done && paddr == OFS_LINE_STATUS));
  COV_BREAK_READ: cover property (line_status_val[LS_BREAK] ##1 pop);
  COV_LOOPBACK: cover property (loopback && st_r.modem_control_reg[MC_RTS]);
  COV_DIV4: cover property (div4 && baud_clk_en);

endmodule // uart_mcls

// file: verif/modem_partner.sv
// partner model: modem or peripheral on the far side of the serial line
// assumes the bench tells it which handshake lines to assert
`timescale 1ns/1ps
module modem_partner (
  // requests from the bench
  input wire logic clear_to_send,
  input wire logic set_ready,
  // serial and modem pins
  input wire logic tx_pin,
  input wire logic rts_pin_n,
  output logic rx_pin,
  output logic cts_pin_n,
  output logic dsr_pin_n
);
  // echoes the line back, as a modem in remote loopback
  assign rx_pin = tx_pin;
  // handshake inputs of the uart are active low
  assign cts_pin_n = ~clear_to_send;
  assign dsr_pin_n = ~set_ready;
endmodule // modem_partner

// file: verif/tb.sv
// self-checking bench for the modem-control and line-status block
// assumes apb with zero or more wait states and a 100 MHz pclk
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  import uart_mcls_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr, rx_char_valid, rx_char_break, rx_char_framing, rx_char_parity;
  logic [7:0] rx_char_data, flow_threshold, fifo_trigger_level;
  logic rx_serial_to_core, tx_serial_from_core, tx_hold_empty, tx_shift_empty;
  logic auto_rts_level_n, baud_clk_en, irda_mode, xon_any_en;
  logic rx_pin, tx_pin, cts_pin_n, dsr_pin_n, rts_pin_n, shared_pin_b_five;
  logic clear_to_send, set_ready;
  int mismatches, n_checks, cycles;

  uart_mcls dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_char_break(rx_char_break), .rx_char_framing(rx_char_framing),
    .rx_char_parity(rx_char_parity), .rx_serial_to_core(rx_serial_to_core),
    .tx_serial_from_core(tx_serial_from_core), .tx_hold_empty(tx_hold_empty),
    .tx_shift_empty(tx_shift_empty), .auto_rts_level_n(auto_rts_level_n),
    .baud_clk_en(baud_clk_en), .irda_mode(irda_mode), .xon_any_en(xon_any_en),
    .flow_threshold(flow_threshold), .fifo_trigger_level(fifo_trigger_level),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n),
    .rts_pin_n(rts_pin_n), .shared_pin_b_five(shared_pin_b_five));

  modem_partner modem_u (.clear_to_send(clear_to_send), .set_ready(set_ready),
    .tx_pin(tx_pin), .rts_pin_n(rts_pin_n), .rx_pin(rx_pin), .cts_pin_n(cts_pin_n),
    .dsr_pin_n(dsr_pin_n));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task finish_test;
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // let the written value reach the outputs before they are looked at
    @(negedge pclk);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask

  task push(input logic [7:0] d, input logic b, input logic f, input logic p);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_break <= b;
    rx_char_framing <= f;
    rx_char_parity <= p;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
  endtask

  task count_baud(input int e);
    int n;
    n = 0;
    repeat (8)
    begin
      @(negedge pclk);
      if (baud_clk_en === 1'b1) n++;
    end
    `CHK(n, e)
  endtask

  task t_reset;
    rd_chk(OFS_MODEM_CONTROL, 32'h0);
    rd_chk(OFS_LINE_STATUS, 32'h60);
    `CHK(rts_pin_n, 1'b1)
    apb(1'b0, 8'h24, 32'h0);
    `CHK(rdat, 32'h0)
    `CHK(rerr, 1'b1)
  endtask

  task t_lock;
    wr(OFS_MODEM_CONTROL, 32'hF7);
    rd_chk(OFS_MODEM_CONTROL, 32'h13);
    wr(OFS_FLOW_THRESHOLD, 32'h55);
    rd_chk(OFS_FLOW_THRESHOLD, 32'h0);
    wr(OFS_ENH_FEATURE, 32'h10);
    wr(OFS_MODEM_CONTROL, 32'hE4);
    rd_chk(OFS_MODEM_CONTROL, 32'hE4);
    `CHK(irda_mode, 1'b1)
    `CHK(xon_any_en, 1'b1)
    wr(OFS_FLOW_THRESHOLD, 32'h55);
    wr(OFS_TRIGGER_LEVEL, 32'hA6);
    `CHK(flow_threshold, 8'h55)
    `CHK(fifo_trigger_level, 8'hA6)
    count_baud(2);
    wr(OFS_MODEM_CONTROL, 32'h00);
    `CHK(irda_mode, 1'b0)
    `CHK(xon_any_en, 1'b0)
    rd_chk(OFS_TRIGGER_LEVEL, 32'h0);
    count_baud(8);
  endtask

  task t_modem;
    wr(OFS_MODEM_CONTROL, 32'h03);
    `CHK(rts_pin_n, 1'b0)
    wr(OFS_PIN_FUNCTION, 32'h02);
    wr(OFS_PORT_PIN_STATE, 32'h20);
    `CHK(shared_pin_b_five, 1'b0)
    wr(OFS_MODEM_CONTROL, 32'h00);
    wr(OFS_PORT_PIN_STATE, 32'h00);
    `CHK(shared_pin_b_five, 1'b1)
    `CHK(rts_pin_n, 1'b1)
    @(posedge pclk);
    clear_to_send <= 1'b1;
    set_ready <= 1'b1;
    repeat (3) @(posedge pclk);
    rd_chk(OFS_MODEM_STATUS, 32'h30);
    wr(OFS_ENH_FEATURE, 32'h50);
    @(posedge pclk);
    auto_rts_level_n <= 1'b0;
    @(negedge pclk);
    `CHK(rts_pin_n, 1'b0)
    wr(OFS_MODEM_CONTROL, 32'h02);
    @(posedge pclk);
    auto_rts_level_n <= 1'b1;
    @(negedge pclk);
    `CHK(rts_pin_n, 1'b1)
    wr(OFS_ENH_FEATURE, 32'h10);
  endtask

  task t_loop;
    @(posedge pclk);
    tx_serial_from_core <= 1'b0;
    repeat (3) @(negedge pclk);
    `CHK(tx_pin, 1'b0)
    `CHK(rx_serial_to_core, 1'b0)
    wr(OFS_MODEM_CONTROL, 32'h11);
    repeat (2) @(negedge pclk);
    `CHK(rx_serial_to_core, 1'b0)
    `CHK(tx_pin, 1'b1)
    rd_chk(OFS_MODEM_STATUS, 32'h20);
    wr(OFS_MODEM_CONTROL, 32'h12);
    `CHK(rts_pin_n, 1'b1)
    rd_chk(OFS_MODEM_STATUS, 32'h10);
    tx_serial_from_core <= 1'b1;
    wr(OFS_MODEM_CONTROL, 32'h00);
  endtask

  task t_tx;
    logic [31:0] e;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      {tx_hold_empty, tx_shift_empty} <= i[1:0];
      e = 32'h0;
      e[6] = (i == 3);
      e[5] = i[1];
      rd_chk(OFS_LINE_STATUS, e);
    end
  endtask

  task t_errors;
    push(8'hA1, 1'b0, 1'b0, 1'b1);
    push(8'hB2, 1'b0, 1'b0, 1'b0);
    push(8'h55, 1'b1, 1'b0, 1'b0);
    push(8'hC3, 1'b0, 1'b1, 1'b0);
    rd_chk(OFS_LINE_STATUS, 32'hE5);
    rd_chk(OFS_RX_HOLDING, 32'hA1);
    rd_chk(OFS_LINE_STATUS, 32'hE1);
    rd_chk(OFS_RX_HOLDING, 32'hB2);
    rd_chk(OFS_LINE_STATUS, 32'hF1);
    rd_chk(OFS_RX_HOLDING, 32'h00);
    rd_chk(OFS_LINE_STATUS, 32'hE9);
    rd_chk(OFS_RX_HOLDING, 32'hC3);
    rd_chk(OFS_LINE_STATUS, 32'h60);
  endtask

  task t_overrun;
    for (int i = 0; i <= RX_DEPTH; i++)
      push(i[7:0], 1'b0, 1'b0, 1'b0);
    rd_chk(OFS_LINE_STATUS, 32'h63);
    rd_chk(OFS_LINE_STATUS, 32'h61);
    for (int i = 0; i < RX_DEPTH; i++)
      rd_chk(OFS_RX_HOLDING, {24'h0, i[7:0]});
    rd_chk(OFS_LINE_STATUS, 32'h60);
  endtask

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, rx_char_valid} = 4'h0;
    {rx_char_break, rx_char_framing, rx_char_parity} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_char_data = 8'h00;
    {tx_serial_from_core, tx_hold_empty, tx_shift_empty, auto_rts_level_n} = 4'hF;
    {clear_to_send, set_ready} = 2'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lock();
    t_modem();
    t_loop();
    t_tx();
    t_errors();
    t_overrun();
    finish_test();
  end
endmodule // tb
